/* rtirq_map.svh */
// register offsets, field positions and reset values of the irq block
`ifndef RTIRQ_MAP_SVH
`define RTIRQ_MAP_SVH
`define RTIRQ_VS_STAT_ADDR 8'h0E
`define RTIRQ_VS_MASK_ADDR 8'h0F
`define RTIRQ_VS_SENSE_ADDR 8'h10
`define RTIRQ_LR_STAT_ADDR 8'h18
`define RTIRQ_LR_MASK_ADDR 8'h19
`define RTIRQ_LR_SENSE_ADDR 8'h1A
`define RTIRQ_TP_STAT_ADDR 8'h20
`define RTIRQ_TP_MASK_ADDR 8'h21
`define RTIRQ_TP_SENSE_ADDR 8'h22
`define RTIRQ_VS_BITS 8'h03
`define RTIRQ_LR_BITS 8'h07
`define RTIRQ_TP_BITS 8'h05
`define RTIRQ_TP_LOW_POS 0
`define RTIRQ_TP_HIGH_POS 2
`define RTIRQ_STAT_RST 8'h00
`define RTIRQ_MASK_RST 8'hFF
`define RTIRQ_SENSE_RST 8'h00
`endif

/* rtirq_pkg.sv */
// types shared by the irq block
package rtirq_pkg;
   // one register access from the host
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } rtirq_acc_s;
   // live conditions from the analog side
   typedef struct packed {
      logic [1:0] buck_ramp;
      logic [2:0] linreg_fault;
      logic temp_above_low;
      logic temp_above_high;
   } rtirq_live_s;
   typedef logic [7:0] rtirq_byte_t;
endpackage : rtirq_pkg

/* rtirq_regs.sv */
// interrupt status, mask and sense registers of the regulator block
`timescale 1ns/10ps
`include "rtirq_map.svh"
module rtirq_regs (
   input wire logic sys_clk_in,
   input wire logic arst_n_in,
   input wire rtirq_pkg::rtirq_acc_s acc_in,
   input wire rtirq_pkg::rtirq_live_s live_in,
   output rtirq_pkg::rtirq_byte_t rdata_out,
   output logic irq_out_n
);
   import rtirq_pkg::*;

   // ======================================================
   // live sense capture
   rtirq_byte_t vs_sense_reg, lr_sense_reg, tp_sense_reg;
   rtirq_byte_t vs_sense_next, lr_sense_next, tp_sense_next;
   assign vs_sense_next = {6'h00, live_in.buck_ramp};
   assign lr_sense_next = {5'h00, live_in.linreg_fault};
   assign tp_sense_next = {5'h00, live_in.temp_above_high, 1'b0,
                           live_in.temp_above_low};

   // ======================================================
   // event detection
   // ramp done is the falling edge of the ramp busy sense
   wire rtirq_byte_t vs_evt = vs_sense_reg & ~vs_sense_next
                              & `RTIRQ_VS_BITS;
   // fault entry is the rising edge of the live fault
   wire rtirq_byte_t lr_evt = lr_sense_next & ~lr_sense_reg
                              & `RTIRQ_LR_BITS;
   // both directions count; bit 1 never sets
   wire rtirq_byte_t tp_evt = (tp_sense_next ^ tp_sense_reg)
                              & `RTIRQ_TP_BITS;

   // ======================================================
   // address decode
   function automatic logic hit(input rtirq_acc_s a, input logic [7:0] ad);
      hit = a.addr == ad;
   endfunction : hit
   wire logic rd_vs_stat = acc_in.rd && hit(acc_in, `RTIRQ_VS_STAT_ADDR);
   wire logic rd_lr_stat = acc_in.rd && hit(acc_in, `RTIRQ_LR_STAT_ADDR);
   wire logic rd_tp_stat = acc_in.rd && hit(acc_in, `RTIRQ_TP_STAT_ADDR);
   wire logic wr_vs_stat = acc_in.wr && hit(acc_in, `RTIRQ_VS_STAT_ADDR);
   wire logic wr_lr_stat = acc_in.wr && hit(acc_in, `RTIRQ_LR_STAT_ADDR);
   wire logic wr_tp_stat = acc_in.wr && hit(acc_in, `RTIRQ_TP_STAT_ADDR);
   wire logic wr_vs_mask = acc_in.wr && hit(acc_in, `RTIRQ_VS_MASK_ADDR);
   wire logic wr_lr_mask = acc_in.wr && hit(acc_in, `RTIRQ_LR_MASK_ADDR);
   wire logic wr_tp_mask = acc_in.wr && hit(acc_in, `RTIRQ_TP_MASK_ADDR);

   // ======================================================
   // sticky status; a new event wins over a clear in the same cycle
   rtirq_byte_t vs_stat_reg, lr_stat_reg, tp_stat_reg;
   rtirq_byte_t vs_stat_next, lr_stat_next, tp_stat_next;
   rtirq_byte_t vs_clr, lr_clr, tp_clr;
   function automatic rtirq_byte_t clr_of(input logic rd, input logic wr,
         input rtirq_byte_t wd);
      clr_of = rd ? 8'hFF : (wr ? wd : 8'h00);
   endfunction : clr_of
   assign vs_clr = clr_of(rd_vs_stat, wr_vs_stat, acc_in.wdata);
   assign lr_clr = clr_of(rd_lr_stat, wr_lr_stat, acc_in.wdata);
   assign tp_clr = clr_of(rd_tp_stat, wr_tp_stat, acc_in.wdata);
   assign vs_stat_next = (vs_stat_reg & ~vs_clr) | vs_evt;
   assign lr_stat_next = (lr_stat_reg & ~lr_clr) | lr_evt;
   assign tp_stat_next = (tp_stat_reg & ~tp_clr) | tp_evt;

   // ======================================================
   // masks; unused bits stay zero
   rtirq_byte_t vs_mask_reg, lr_mask_reg, tp_mask_reg;
   rtirq_byte_t vs_mask_next, lr_mask_next, tp_mask_next;
   assign vs_mask_next = wr_vs_mask ? (acc_in.wdata & `RTIRQ_VS_BITS)
                                    : vs_mask_reg;
   assign lr_mask_next = wr_lr_mask ? (acc_in.wdata & `RTIRQ_LR_BITS)
                                    : lr_mask_reg;
   assign tp_mask_next = wr_tp_mask ? (acc_in.wdata & `RTIRQ_TP_BITS)
                                    : tp_mask_reg;

   // ======================================================
   // interrupt pin, registered from next-state values so it tracks status
   wire logic irq_any_next = |(vs_stat_next & ~vs_mask_next)
                           | |(lr_stat_next & ~lr_mask_next)
                           | |(tp_stat_next & ~tp_mask_next);

   // ======================================================
   // read data; status read returns the value before the clear
   rtirq_byte_t rdata_next;
   always_comb begin
      case (acc_in.addr)
         `RTIRQ_VS_STAT_ADDR: rdata_next = vs_stat_reg;
         `RTIRQ_VS_MASK_ADDR: rdata_next = vs_mask_reg;
         `RTIRQ_VS_SENSE_ADDR: rdata_next = vs_sense_reg;
         `RTIRQ_LR_STAT_ADDR: rdata_next = lr_stat_reg;
         `RTIRQ_LR_MASK_ADDR: rdata_next = lr_mask_reg;
         `RTIRQ_LR_SENSE_ADDR: rdata_next = lr_sense_reg;
         `RTIRQ_TP_STAT_ADDR: rdata_next = tp_stat_reg;
         `RTIRQ_TP_MASK_ADDR: rdata_next = tp_mask_reg;
         `RTIRQ_TP_SENSE_ADDR: rdata_next = tp_sense_reg;
         default: rdata_next = 8'h00;
      endcase
   end

   // ======================================================
   // registers
   logic irq_n_reg;
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         vs_sense_reg <= `RTIRQ_SENSE_RST;
         lr_sense_reg <= `RTIRQ_SENSE_RST;
         tp_sense_reg <= `RTIRQ_SENSE_RST;
         vs_stat_reg <= `RTIRQ_STAT_RST;
         lr_stat_reg <= `RTIRQ_STAT_RST;
         tp_stat_reg <= `RTIRQ_STAT_RST;
         vs_mask_reg <= `RTIRQ_MASK_RST & `RTIRQ_VS_BITS;
         lr_mask_reg <= `RTIRQ_MASK_RST & `RTIRQ_LR_BITS;
         tp_mask_reg <= `RTIRQ_MASK_RST & `RTIRQ_TP_BITS;
         irq_n_reg <= 1'b1;
         rdata_out <= 8'h00;
      end else begin
         vs_sense_reg <= vs_sense_next;
         lr_sense_reg <= lr_sense_next;
         tp_sense_reg <= tp_sense_next;
         vs_stat_reg <= vs_stat_next;
         lr_stat_reg <= lr_stat_next;
         tp_stat_reg <= tp_stat_next;
         vs_mask_reg <= vs_mask_next;
         lr_mask_reg <= lr_mask_next;
         tp_mask_reg <= tp_mask_next;
         irq_n_reg <= ~irq_any_next;
         rdata_out <= acc_in.rd ? rdata_next : rdata_out;
      end
   end
   assign irq_out_n = irq_n_reg;

   // ======================================================
   // checks
   wire logic unmasked = |(vs_stat_reg & ~vs_mask_reg)
                       | |(lr_stat_reg & ~lr_mask_reg)
                       | |(tp_stat_reg & ~tp_mask_reg);
   property p_irq_low;
      @(posedge sys_clk_in) disable iff (!arst_n_in) unmasked |-> !irq_out_n;
   endproperty
   a_irq_low: assert property (p_irq_low)
      else $error("unmasked status without irq");
   property p_irq_high;
      @(posedge sys_clk_in) disable iff (!arst_n_in) !unmasked |-> irq_out_n;
   endproperty
   a_irq_high: assert property (p_irq_high)
      else $error("irq low with nothing unmasked");
   property p_vs_mask_bits;
      @(posedge sys_clk_in) disable iff (!arst_n_in)
         (vs_mask_reg & ~`RTIRQ_VS_BITS) == 8'h00;
   endproperty
   a_vs_mask_bits: assert property (p_vs_mask_bits)
      else $error("ramp mask unused bit set");
   property p_vs_sense;
      @(posedge sys_clk_in) disable iff (!arst_n_in)
         1'b1 |=> vs_sense_reg[1:0] == $past(live_in.buck_ramp);
   endproperty
   a_vs_sense: assert property (p_vs_sense)
      else $error("ramp sense does not follow ramp");
   property p_read_clear;
      @(posedge sys_clk_in) disable iff (!arst_n_in)
         rd_lr_stat && lr_evt == 8'h00 |=> lr_stat_reg == 8'h00;
   endproperty
   a_read_clear: assert property (p_read_clear)
      else $error("status not cleared by read");
   property p_sticky;
      @(posedge sys_clk_in) disable iff (!arst_n_in)
         tp_stat_reg[0] && !rd_tp_stat && !(wr_tp_stat && acc_in.wdata[0])
         |=> tp_stat_reg[0];
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("status dropped without clear");
   property p_lr_set;
      @(posedge sys_clk_in) disable iff (!arst_n_in)
         lr_sense_next[0] && !lr_sense_reg[0] |=> lr_stat_reg[0];
   endproperty
   a_lr_set: assert property (p_lr_set)
      else $error("linreg fault not latched");
   sequence s_temp_fall;
      tp_sense_reg[`RTIRQ_TP_HIGH_POS] ##1 !tp_sense_reg[`RTIRQ_TP_HIGH_POS];
   endsequence
   property p_temp_fall;
      @(posedge sys_clk_in) disable iff (!arst_n_in)
         s_temp_fall |-> tp_stat_reg[`RTIRQ_TP_HIGH_POS];
   endproperty
   a_temp_fall: assert property (p_temp_fall)
      else $error("falling high crossing not latched");
   property p_temp_unused;
      @(posedge sys_clk_in) disable iff (!arst_n_in) !tp_stat_reg[1];
   endproperty
   a_temp_unused: assert property (p_temp_unused)
      else $error("unused temp bit set");
   property p_ramp_done;
      @(posedge sys_clk_in) disable iff (!arst_n_in)
         vs_sense_reg[0] && !vs_sense_next[0] |=> vs_stat_reg[0];
   endproperty
   a_ramp_done: assert property (p_ramp_done)
      else $error("ramp done not latched");

   // ======================================================
   // reset values; the first edge after release still shows them
   property p_stat_reset;
      @(posedge sys_clk_in) disable iff (!arst_n_in)
         $rose(arst_n_in) |-> (vs_stat_reg | lr_stat_reg | tp_stat_reg)
            == `RTIRQ_STAT_RST;
   endproperty
   a_stat_reset: assert property (p_stat_reset)
      else $error("status not zero after reset");
   property p_vs_mask_reset;
      @(posedge sys_clk_in) disable iff (!arst_n_in)
         $rose(arst_n_in) |-> vs_mask_reg == `RTIRQ_VS_BITS;
   endproperty
   a_vs_mask_reset: assert property (p_vs_mask_reset)
      else $error("ramp mask not all ones after reset");
   property p_lr_mask_reset;
      @(posedge sys_clk_in) disable iff (!arst_n_in)
         $rose(arst_n_in) |-> lr_mask_reg == `RTIRQ_LR_BITS;
   endproperty
   a_lr_mask_reset: assert property (p_lr_mask_reset)
      else $error("linreg mask not all ones after reset");
   property p_vs_sense_reset;
      @(posedge sys_clk_in) disable iff (!arst_n_in)
         $rose(arst_n_in) |-> vs_sense_reg == `RTIRQ_SENSE_RST;
   endproperty
   a_vs_sense_reset: assert property (p_vs_sense_reset)
      else $error("ramp sense not zero after reset");
   property p_lr_sense_reset;
      @(posedge sys_clk_in) disable iff (!arst_n_in)
         $rose(arst_n_in) |-> lr_sense_reg == `RTIRQ_SENSE_RST;
   endproperty
   a_lr_sense_reset: assert property (p_lr_sense_reset)
      else $error("linreg sense not zero after reset");

   // ======================================================
   // register behaviour
   property p_lr_mask_bits;
      @(posedge sys_clk_in) disable iff (!arst_n_in)
         (lr_mask_reg & ~`RTIRQ_LR_BITS) == 8'h00;
   endproperty
   a_lr_mask_bits: assert property (p_lr_mask_bits)
      else $error("linreg mask unused bit set");
   property p_tp_mask_bits;
      @(posedge sys_clk_in) disable iff (!arst_n_in)
         (tp_mask_reg & ~`RTIRQ_TP_BITS) == 8'h00;
   endproperty
   a_tp_mask_bits: assert property (p_tp_mask_bits)
      else $error("temp mask unused bit set");
   property p_lr_sense;
      @(posedge sys_clk_in) disable iff (!arst_n_in)
         1'b1 |=> lr_sense_reg[2:0] == $past(live_in.linreg_fault);
   endproperty
   a_lr_sense: assert property (p_lr_sense)
      else $error("linreg sense does not follow fault");
   property p_write_clear;
      @(posedge sys_clk_in) disable iff (!arst_n_in)
         wr_lr_stat && lr_evt == 8'h00
         |=> (lr_stat_reg & $past(acc_in.wdata)) == 8'h00;
   endproperty
   a_write_clear: assert property (p_write_clear)
      else $error("status not cleared by write one");
   property p_stay_clear;
      @(posedge sys_clk_in) disable iff (!arst_n_in)
         lr_stat_reg == 8'h00 && lr_evt == 8'h00 |=> lr_stat_reg == 8'h00;
   endproperty
   a_stay_clear: assert property (p_stay_clear)
      else $error("status set without event");
   property p_read_value;
      @(posedge sys_clk_in) disable iff (!arst_n_in)
         rd_lr_stat |=> rdata_out == $past(lr_stat_reg);
   endproperty
   a_read_value: assert property (p_read_value)
      else $error("status read lost its value");
   property p_irq_event;
      @(posedge sys_clk_in) disable iff (!arst_n_in)
         (lr_evt & ~lr_mask_next) != 8'h00 |=> !irq_out_n;
   endproperty
   a_irq_event: assert property (p_irq_event)
      else $error("unmasked event did not pull irq");

   // ======================================================
   // threshold crossings and ramp ends
   sequence s_low_rise;
      !tp_sense_reg[`RTIRQ_TP_LOW_POS] ##1 tp_sense_reg[`RTIRQ_TP_LOW_POS];
   endsequence
   property p_low_rise;
      @(posedge sys_clk_in) disable iff (!arst_n_in)
         s_low_rise |-> tp_stat_reg[`RTIRQ_TP_LOW_POS];
   endproperty
   a_low_rise: assert property (p_low_rise)
      else $error("rising low crossing not latched");
   sequence s_low_fall;
      tp_sense_reg[`RTIRQ_TP_LOW_POS] ##1 !tp_sense_reg[`RTIRQ_TP_LOW_POS];
   endsequence
   property p_low_fall;
      @(posedge sys_clk_in) disable iff (!arst_n_in)
         s_low_fall |-> tp_stat_reg[`RTIRQ_TP_LOW_POS];
   endproperty
   a_low_fall: assert property (p_low_fall)
      else $error("falling low crossing not latched");
   sequence s_high_rise;
      !tp_sense_reg[`RTIRQ_TP_HIGH_POS] ##1 tp_sense_reg[`RTIRQ_TP_HIGH_POS];
   endsequence
   property p_high_rise;
      @(posedge sys_clk_in) disable iff (!arst_n_in)
         s_high_rise |-> tp_stat_reg[`RTIRQ_TP_HIGH_POS];
   endproperty
   a_high_rise: assert property (p_high_rise)
      else $error("rising high crossing not latched");
   sequence s_ramp_b_end;
      vs_sense_reg[1] ##1 !vs_sense_reg[1];
   endsequence
   property p_ramp_b_end;
      @(posedge sys_clk_in) disable iff (!arst_n_in)
         s_ramp_b_end |-> vs_stat_reg[1];
   endproperty
   a_ramp_b_end: assert property (p_ramp_b_end)
      else $error("second ramp done not latched");
endmodule : rtirq_regs

/* rtirq_host.sv */
// host model that issues register reads and writes
`timescale 1ns/10ps
module rtirq_host (
   input wire logic sys_clk_in,
   input wire rtirq_pkg::rtirq_byte_t rdata_in,
   output rtirq_pkg::rtirq_acc_s acc_out
);
   import rtirq_pkg::*;
   initial acc_out = '0;
   // strobes move on the falling edge, clear of the sampling edge
   task automatic write_reg(input rtirq_byte_t a, input rtirq_byte_t d);
      @(negedge sys_clk_in);
      acc_out <= '{1'b0, 1'b1, a, d};
      @(negedge sys_clk_in);
      acc_out <= '0;
   endtask : write_reg
   // read data is registered, so it is taken one cycle after the strobe
   task automatic read_reg(input rtirq_byte_t a, output rtirq_byte_t d);
      @(negedge sys_clk_in);
      acc_out <= '{1'b1, 1'b0, a, 8'h00};
      @(negedge sys_clk_in);
      acc_out <= '0;
      d = rdata_in;
   endtask : read_reg
endmodule : rtirq_host

/* test_rtirq_regs.sv */
// self-checking bench of the irq register block
`timescale 1ns/10ps
`include "rtirq_map.svh"
module test_rtirq_regs;
   import rtirq_pkg::*;
   logic sys_clk_in = 1'b0;
   logic arst_n_in = 1'b0;
   rtirq_acc_s acc;
   rtirq_live_s live = '0;
   rtirq_byte_t rdata;
   logic irq_n;
   int miscompares = 0;
   int comparisons = 0;
   rtirq_host i_host (.sys_clk_in(sys_clk_in), .rdata_in(rdata),
      .acc_out(acc));
   rtirq_regs i_dut (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
      .acc_in(acc), .live_in(live), .rdata_out(rdata), .irq_out_n(irq_n));
   initial forever #5 sys_clk_in = ~sys_clk_in;
   // ==========================================
   // compare helpers
   task automatic chk(input string n, input rtirq_byte_t e, rtirq_byte_t g);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic chk_irq(input logic e);
      comparisons++;
      if (irq_n !== e) begin
         miscompares++;
         $display("MISMATCH irq_out_n expected %b seen %b", e, irq_n);
      end
   endtask : chk_irq
   task automatic rd_chk(input string n, rtirq_byte_t a, rtirq_byte_t e);
      rtirq_byte_t d;
      i_host.read_reg(a, d);
      chk(n, e, d);
   endtask : rd_chk
   // ==========================================
   // scenarios
   task automatic reset_values();
      rd_chk("vs mask", `RTIRQ_VS_MASK_ADDR, 8'h03);
      rd_chk("vs sense", `RTIRQ_VS_SENSE_ADDR, 8'h00);
      rd_chk("vs stat", `RTIRQ_VS_STAT_ADDR, 8'h00);
      rd_chk("lr mask", `RTIRQ_LR_MASK_ADDR, 8'h07);
      rd_chk("lr sense", `RTIRQ_LR_SENSE_ADDR, 8'h00);
      rd_chk("lr stat", `RTIRQ_LR_STAT_ADDR, 8'h00);
      rd_chk("tp stat", `RTIRQ_TP_STAT_ADDR, 8'h00);
      chk_irq(1'b1);
   endtask : reset_values
   task automatic linreg_faults();
      @(negedge sys_clk_in) live.linreg_fault <= 3'b101;
      rd_chk("lr sense", `RTIRQ_LR_SENSE_ADDR, 8'h05);
      chk_irq(1'b1);
      rd_chk("lr stat", `RTIRQ_LR_STAT_ADDR, 8'h05);
      // fault still held: a level must not set the flag again
      rd_chk("lr stat", `RTIRQ_LR_STAT_ADDR, 8'h00);
      i_host.write_reg(`RTIRQ_LR_MASK_ADDR, 8'h00);
      @(negedge sys_clk_in) live.linreg_fault <= 3'b000;
      @(negedge sys_clk_in) live.linreg_fault <= 3'b010;
      @(negedge sys_clk_in) chk_irq(1'b0);
      rd_chk("lr mask", `RTIRQ_LR_MASK_ADDR, 8'h00);
      chk_irq(1'b0);
      i_host.write_reg(`RTIRQ_LR_STAT_ADDR, 8'h02);
      chk_irq(1'b1);
      rd_chk("lr stat", `RTIRQ_LR_STAT_ADDR, 8'h00);
      @(negedge sys_clk_in) live.linreg_fault <= 3'b000;
   endtask : linreg_faults
   task automatic temp_cross();
      @(negedge sys_clk_in) live.temp_above_low <= 1'b1;
      rd_chk("tp stat", `RTIRQ_TP_STAT_ADDR, 8'h01);
      @(negedge sys_clk_in) live.temp_above_low <= 1'b0;
      rd_chk("tp stat", `RTIRQ_TP_STAT_ADDR, 8'h01);
      @(negedge sys_clk_in) live.temp_above_high <= 1'b1;
      rd_chk("tp stat", `RTIRQ_TP_STAT_ADDR, 8'h04);
      @(negedge sys_clk_in) live.temp_above_high <= 1'b0;
      i_host.write_reg(`RTIRQ_TP_STAT_ADDR, 8'hFF);
      rd_chk("tp stat", `RTIRQ_TP_STAT_ADDR, 8'h00);
   endtask : temp_cross
   task automatic ramp_done();
      i_host.write_reg(`RTIRQ_VS_MASK_ADDR, 8'h02);
      @(negedge sys_clk_in) live.buck_ramp <= 2'b01;
      rd_chk("vs sense", `RTIRQ_VS_SENSE_ADDR, 8'h01);
      rd_chk("vs stat", `RTIRQ_VS_STAT_ADDR, 8'h00);
      @(negedge sys_clk_in) live.buck_ramp <= 2'b00;
      @(negedge sys_clk_in) chk_irq(1'b0);
      rd_chk("vs stat", `RTIRQ_VS_STAT_ADDR, 8'h01);
      chk_irq(1'b1);
      rd_chk("vs mask", `RTIRQ_VS_MASK_ADDR, 8'h02);
      @(negedge sys_clk_in) live.buck_ramp <= 2'b10;
      @(negedge sys_clk_in) live.buck_ramp <= 2'b00;
      @(negedge sys_clk_in) chk_irq(1'b1);
      rd_chk("vs stat", `RTIRQ_VS_STAT_ADDR, 8'h02);
   endtask : ramp_done
   task automatic temp_unmask();
      rd_chk("tp mask", `RTIRQ_TP_MASK_ADDR, 8'h05);
      @(negedge sys_clk_in) live.temp_above_high <= 1'b1;
      rd_chk("tp sense", `RTIRQ_TP_SENSE_ADDR, 8'h04);
      i_host.write_reg(`RTIRQ_TP_MASK_ADDR, 8'h00);
      chk_irq(1'b0);
      i_host.write_reg(`RTIRQ_TP_STAT_ADDR, 8'h04);
      chk_irq(1'b1);
      @(negedge sys_clk_in) live.temp_above_high <= 1'b0;
      @(negedge sys_clk_in) chk_irq(1'b0);
      rd_chk("tp stat", `RTIRQ_TP_STAT_ADDR, 8'h04);
      chk_irq(1'b1);
      rd_chk("tp mask", `RTIRQ_TP_MASK_ADDR, 8'h00);
   endtask : temp_unmask
   task automatic ignored_access();
      i_host.write_reg(`RTIRQ_LR_SENSE_ADDR, 8'hFF);
      rd_chk("lr sense", `RTIRQ_LR_SENSE_ADDR, 8'h00);
      i_host.write_reg(`RTIRQ_VS_SENSE_ADDR, 8'hFF);
      rd_chk("vs sense", `RTIRQ_VS_SENSE_ADDR, 8'h00);
      i_host.write_reg(`RTIRQ_LR_MASK_ADDR, 8'hFF);
      rd_chk("lr mask", `RTIRQ_LR_MASK_ADDR, 8'h07);
   endtask : ignored_access
   task automatic reset_again();
      @(negedge sys_clk_in) live.temp_above_low <= 1'b1;
      @(negedge sys_clk_in) chk_irq(1'b0);
      arst_n_in <= 1'b0;
      live.temp_above_low <= 1'b0;
      @(negedge sys_clk_in) chk_irq(1'b1);
      arst_n_in <= 1'b1;
      rd_chk("tp stat", `RTIRQ_TP_STAT_ADDR, 8'h00);
      rd_chk("tp mask", `RTIRQ_TP_MASK_ADDR, 8'h05);
      rd_chk("lr mask", `RTIRQ_LR_MASK_ADDR, 8'h07);
      rd_chk("vs mask", `RTIRQ_VS_MASK_ADDR, 8'h03);
      chk_irq(1'b1);
   endtask : reset_again
   // ==========================================
   // verdict
   task automatic summarize();
      if (miscompares == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : summarize
   // a hang costs a mismatch rather than the whole run
   initial begin
      #100000;
      miscompares++;
      summarize();
   end
   initial begin
      repeat (8) @(negedge sys_clk_in);
      arst_n_in <= 1'b1;
      reset_values();
      linreg_faults();
      temp_cross();
      ramp_done();
      temp_unmask();
      ignored_access();
      reset_again();
      summarize();
   end
endmodule : test_rtirq_regs
